/* design/acl_pkg.sv */
package acl_pkg;
	localparam int unsigned CLK_HZ          = 25000000;
	// rate value of 0 selects the default speed
	localparam logic [31:0] RATE_RESET      = 32'h0001C200;
	localparam logic [31:0] RATE_9600       = 32'h00002580;
	localparam logic [31:0] RATE_19200      = 32'h00004B00;
	localparam logic [31:0] RATE_38400      = 32'h00009600;
	localparam logic [31:0] RATE_57600      = 32'h0000E100;
	localparam logic [31:0] RATE_115200     = 32'h0001C200;
	localparam logic [31:0] ROLE_RESET      = 32'h00000000;
	localparam logic [31:0] ROLE_SLAVE      = 32'h00000000;
	localparam logic [31:0] ROLE_MASTER     = 32'h00000001;
	localparam int unsigned STATUS_ROLE_BIT = 6;
	localparam logic [4:0]  MASTER_AXIS     = 5'h00;
	localparam logic [4:0]  MAX_SLAVE_AXIS  = 5'h1E;
	localparam logic [4:0]  EXT_MASTER_AXIS = 5'h1F;
	localparam logic [7:0]  REC_NORMAL      = 8'h20;
	localparam logic [7:0]  REC_EMERGENCY   = 8'h18;
	localparam logic [7:0]  REC_MONITOR     = 8'h12;
	localparam logic [31:0] SAVE_LINK_ARG   = 32'h00000002;
	// command names that write the stored rate and role settings
	localparam logic [23:0] CMD_RATE        = 24'h4B4C52;
	localparam logic [23:0] CMD_ROLE        = 24'h524F4C;
	// default divide counts at 25 MHz: fast 41.67 us, slow 166.67 us,
	// current 13.89 us
	localparam logic [15:0] FAST_DIV_RESET  = 16'h0412;
	localparam logic [15:0] SLOW_DIV_RESET  = 16'h1046;
	localparam logic [15:0] CUR_DIV_RESET   = 16'h015B;
	localparam logic [7:0]  CH_DOT          = 8'h2E;
	localparam logic [7:0]  CH_EQ           = 8'h3D;
	localparam logic [7:0]  CH_COMMA        = 8'h2C;
	localparam logic [7:0]  CH_BANG         = 8'h21;
	localparam logic [7:0]  CH_PCT          = 8'h25;
	localparam logic [7:0]  CH_CR           = 8'h0D;
	localparam logic [7:0]  CH_ZERO         = 8'h30;
	localparam logic [7:0]  CH_NINE         = 8'h39;
	localparam logic [7:0]  CH_A            = 8'h41;
	localparam logic [7:0]  CH_Z            = 8'h5A;

	typedef struct packed {
		logic        valid;
		logic [23:0] name;
		logic [31:0] axis_mask;
		logic [31:0] p1;
		logic [31:0] p2;
		logic        bad;
	} acl_cmd_t;

	typedef struct packed {
		logic slow;
		logic fast;
		logic cur;
	} acl_ticks_t;
endpackage : acl_pkg

/* design/acl_tick_div.sv */
`timescale 1ns/1ns
`default_nettype none
module acl_tick_div (
	input  wire logic        clk_i,   // base clock
	input  wire logic        rst_i,   // sync reset
	input  wire logic [15:0] div_i,   // divide count
	output logic             tick_o   // one-cycle pulse at wrap
);
	logic [15:0] cnt;
	logic [15:0] next_cnt;
	logic        next_tick;

	always_comb begin
		// count up to the divide count, restart, pulse at wrap
		if (cnt + 16'h0001 >= div_i) begin // RULE_23
			next_cnt  = 16'h0000;
			next_tick = 1'b1;
		end else begin
			next_cnt  = cnt + 16'h0001;
			next_tick = 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt    <= 16'h0000;
			tick_o <= 1'b0;
		end else begin
			cnt    <= next_cnt;
			tick_o <= next_tick;
		end
	end
endmodule : acl_tick_div
`default_nettype wire

/* design/acl_uart_rx.sv */
`timescale 1ns/1ns
`default_nettype none
module acl_uart_rx (
	input  wire logic        clk_i,   // base clock
	input  wire logic        rst_i,   // sync reset
	input  wire logic [15:0] bit_div_i, // clocks per bit
	input  wire logic        rx_i,    // serial line, idle high
	output logic [7:0]       data_o,  // received byte
	output logic             valid_o  // one-cycle pulse per byte
);
	typedef enum {IDLE, START, DATA, STOP} acl_rx_st_t;
	acl_rx_st_t  st, next_st;
	logic [15:0] cnt, next_cnt;
	logic [2:0]  bitn, next_bitn;
	logic [7:0]  sh, next_sh;
	logic [7:0]  next_data;
	logic        next_valid;

	always_comb begin
		next_st    = st;
		next_cnt   = cnt + 16'h0001;
		next_bitn  = bitn;
		next_sh    = sh;
		next_data  = data_o;
		next_valid = 1'b0;
		unique case (st)
			IDLE: begin
				next_cnt = 16'h0000;
				if (!rx_i)
					next_st = START;
			end
			START: if (cnt == {1'b0, bit_div_i[15:1]}) begin
				next_cnt = 16'h0000;
				next_bitn = 3'h0;
				next_st  = rx_i ? IDLE : DATA;
			end
			DATA: if (cnt == bit_div_i - 16'h0001) begin
				next_cnt  = 16'h0000;
				next_sh   = {rx_i, sh[7:1]};
				next_bitn = bitn + 3'h1;
				if (bitn == 3'h7)
					next_st = STOP;
			end
			STOP: if (cnt == bit_div_i - 16'h0001) begin
				next_st = IDLE;
				if (rx_i) begin
					next_data  = sh;
					next_valid = 1'b1;
				end
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st      <= IDLE;
			cnt     <= 16'h0000;
			bitn    <= 3'h0;
			sh      <= 8'h00;
			data_o  <= 8'h00;
			valid_o <= 1'b0;
		end else begin
			st      <= next_st;
			cnt     <= next_cnt;
			bitn    <= next_bitn;
			sh      <= next_sh;
			data_o  <= next_data;
			valid_o <= next_valid;
		end
	end
endmodule : acl_uart_rx
`default_nettype wire

/* design/acl_core.sv */
// Contract
// (RULE_01) fast tick drives interpolation, position loop and host link service
// (RULE_02) fast period is fast divide count over base rate count
// (RULE_03) current tick period is current divide count over base rate count
// (RULE_04) host link defaults to 115200 bit/s
// (RULE_05) rate select picks 9600, 19200, 38400, 57600 or 115200
// (RULE_06) new rate applies only at power-on after save with argument 2; here any reset applies the stored rate, with no save step
// (RULE_07) dual-axis parts need the same rate stored on both axes
// (RULE_08) chain axes hold unique numbers 0..30; external master is 31
// (RULE_09) chain master forwards host or own orders to addressed slaves
// (RULE_10) on-chain master always uses axis number 0
// (RULE_11) role 0 selects slave, the default; role 1 selects master
// (RULE_12) role applies only at power-on after save and reset; here any reset applies the stored role, with no save step
// (RULE_13) status word bit 6 shows the active role
// (RULE_14) master issues normal 20H, emergency 18H and monitor 12H records
// (RULE_15) master runs its sequence while accepting host commands
// (RULE_16) multi-axis interpolation unavailable with on-chain master alone
// (RULE_17) only the on-chain master reports the present axes mask
// (RULE_18) on-chain master must not be used with a field bus board
// (RULE_19) command is name, dot, axis selector, optional =p1 and ,p2
// (RULE_20) selector: 0..30, ! for all, comma list, or % mask
// (RULE_21) omitted parameters are 0; = only needed with parameters
// (RULE_22) slow tick runs sequences, chain commands and trajectory
// (RULE_23) tick counters wrap at divide count with one-cycle pulse
`timescale 1ns/1ns
`default_nettype none
module acl_core (
	input  wire logic        clk_i,          // 25 MHz base clock
	input  wire logic        rst_i,          // sync reset, power-on
	input  wire logic        rx_i,           // host serial input
	input  wire logic [15:0] fast_divide_count_i, // fast divide count
	input  wire logic [15:0] slow_divide_count_i, // slow divide count
	input  wire logic [15:0] current_divide_count_i, // current divide
	input  wire logic [4:0]  axis_number_i,  // strapped axis number
	input  wire logic        ext_master_i,   // external master present
	input  wire logic [31:0] chain_present_i, // axes seen on chain
	input  wire logic        seq_req_i,      // own sequence order
	input  wire logic [7:0]  seq_rec_i,      // own sequence record type
	input  wire logic [31:0] seq_mask_i,     // own sequence axis mask
	output acl_pkg::acl_ticks_t ticks_o,     // slow, fast, current
	output acl_pkg::acl_cmd_t   cmd_o,       // parsed host command
	output logic [31:0]      host_link_rate_select_o, // stored rate
	output logic [31:0]      operating_role_select_o, // stored role
	output logic [31:0]      status_monitoring_word_o, // status word
	output logic [31:0]      present_axes_mask_o, // axes mask
	output logic [15:0]      bit_div_o,      // active clocks per bit
	output logic [4:0]       eff_axis_o,     // active axis number
	output logic             interp_ok_o,    // interpolation available
	output logic             fwd_valid_o,    // forward to chain
	output logic [7:0]       fwd_rec_o,      // forwarded record type
	output logic [31:0]      fwd_mask_o,     // forwarded axis mask
	output logic             fast_service_o, // link/loop service strobe
	output logic             slow_service_o  // sequence service strobe
);
	typedef enum {P_NAME, P_AXIS, P_P1, P_P2, P_SKIP} acl_ps_t;

	logic        rx_valid;
	logic [7:0]  rx_data;
	logic        is_dig;
	logic [3:0]  dig;

	// stored (non-volatile image) and active (latched at power-on)
	logic [31:0] rate_store, next_rate_store;
	logic [31:0] role_store, next_role_store;
	logic [31:0] rate_act, next_rate_act;
	logic        master, next_master;
	logic        boot, next_boot;
	logic [15:0] bit_div, next_bit_div;

	acl_ps_t     ps, next_ps;
	logic [1:0]  ncnt, next_ncnt;
	logic [23:0] name, next_name;
	logic [31:0] num, next_num;
	logic [31:0] amask, next_amask;
	logic        pct, next_pct;
	logic [31:0] p1, next_p1;
	acl_pkg::acl_cmd_t cmd, next_cmd;
	logic        next_fwd_valid;
	logic [7:0]  next_fwd_rec;
	logic [31:0] next_fwd_mask;

	logic [2:0][15:0] tick_div;
	logic [2:0]       tick;

	// index order matches the tick struct: slow, fast, current
	assign tick_div = {slow_divide_count_i, fast_divide_count_i,
		current_divide_count_i};
	for (genvar i = 0; i < 3; i++) begin : g_tick // RULE_02 RULE_03
		acl_tick_div u_div (
			.clk_i  (clk_i),
			.rst_i  (rst_i),
			.div_i  (tick_div[i]),
			.tick_o (tick[i])
		);
	end
	assign ticks_o = tick;

	acl_uart_rx u_rx (
		.clk_i     (clk_i),
		.rst_i     (rst_i),
		.bit_div_i (bit_div),
		.rx_i      (rx_i),
		.data_o    (rx_data),
		.valid_o   (rx_valid)
	);

	assign fast_service_o = ticks_o.fast; // RULE_01
	assign slow_service_o = ticks_o.slow; // RULE_22
	assign is_dig = rx_data >= acl_pkg::CH_ZERO && rx_data <= acl_pkg::CH_NINE;
	assign dig    = 4'(rx_data - acl_pkg::CH_ZERO);

	function automatic logic [15:0] rate_div(input logic [31:0] r);
		logic [31:0] q;
		unique case (r) // RULE_05
			acl_pkg::RATE_9600:  q = acl_pkg::CLK_HZ / 9600;
			acl_pkg::RATE_19200: q = acl_pkg::CLK_HZ / 19200;
			acl_pkg::RATE_38400: q = acl_pkg::CLK_HZ / 38400;
			acl_pkg::RATE_57600: q = acl_pkg::CLK_HZ / 57600;
			default:             q = acl_pkg::CLK_HZ / 115200; // RULE_04
		endcase
		return q[15:0];
	endfunction : rate_div

	// configuration: stored values change by command, active ones by reset
	always_comb begin
		next_rate_store = rate_store;
		next_role_store = role_store;
		next_rate_act   = rate_act;
		next_master     = master;
		next_boot       = 1'b0;
		next_bit_div    = bit_div;
		if (boot) begin
			next_rate_act = rate_store; // RULE_06
			next_bit_div  = rate_div(rate_store);
			next_master   = role_store == acl_pkg::ROLE_MASTER; // RULE_11 RULE_12
		end
		if (cmd.valid && !cmd.bad && cmd.axis_mask[eff_axis_o]) begin
			// settings are written by command name, value in p1
			if (cmd.name == acl_pkg::CMD_RATE)
				next_rate_store = cmd.p1;
			if (cmd.name == acl_pkg::CMD_ROLE)
				next_role_store = cmd.p1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			boot <= 1'b1;
			bit_div <= rate_div(acl_pkg::RATE_RESET);
			rate_act <= acl_pkg::RATE_RESET;
			master <= 1'b0;
		end else begin
			boot <= next_boot;
			bit_div <= next_bit_div;
			rate_act <= next_rate_act;
			master <= next_master;
		end
	end

	// stored image survives reset: only a clear at first clock would lose it
	logic init_done = 1'b0;
	always_ff @(posedge clk_i) begin
		if (!init_done) begin
			init_done  <= 1'b1;
			rate_store <= acl_pkg::RATE_RESET;
			role_store <= acl_pkg::ROLE_RESET;
		end else begin
			rate_store <= next_rate_store;
			role_store <= next_role_store;
		end
	end
	// command parser: NAME.AXIS[=P1][,P2] terminated by CR
	always_comb begin
		next_ps    = ps;
		next_ncnt  = ncnt;
		next_name  = name;
		next_num   = num;
		next_amask = amask;
		next_pct   = pct;
		next_p1    = p1;
		next_cmd   = cmd;
		next_cmd.valid = 1'b0;
		if (rx_valid) begin
			if (rx_data == acl_pkg::CH_CR) begin
				next_ps = P_NAME;
				next_ncnt = 2'h0;
				next_cmd.valid = 1'b1;
				next_cmd.name  = name;
				next_cmd.bad   = ps == P_NAME || ps == P_SKIP;
				next_cmd.p1 = p1;
				next_cmd.p2 = 32'h0; // RULE_21
				unique case (ps)
					P_AXIS: begin
						next_cmd.axis_mask = pct ? num : (amask |
							(32'h1 << num[4:0]));
						next_cmd.p1 = 32'h0; // RULE_21
						next_cmd.bad = !pct && num > 32'(acl_pkg::MAX_SLAVE_AXIS);
					end
					P_P1: next_cmd.p1 = num;
					P_P2: next_cmd.p2 = num;
					default: ;
				endcase
				next_num = 32'h0;
				next_amask = 32'h0;
				next_pct = 1'b0;
			end else begin
				unique case (ps)
					P_NAME: if (ncnt == 2'h3 && rx_data == acl_pkg::CH_DOT) // RULE_19
						next_ps = P_AXIS;
					else if (ncnt != 2'h3 && rx_data >= acl_pkg::CH_A &&
						rx_data <= acl_pkg::CH_Z) begin
						next_name = {name[15:0], rx_data};
						next_ncnt = ncnt + 2'h1;
					end else
						next_ps = P_SKIP;
					P_AXIS: if (is_dig)
						next_num = 32'(num * 32'd10 + 32'(dig));
					else if (rx_data == acl_pkg::CH_BANG) // RULE_20
						next_amask = {1'b0, {31{1'b1}}};
					else if (rx_data == acl_pkg::CH_PCT)
						next_pct = 1'b1;
					else if (rx_data == acl_pkg::CH_COMMA) begin
						next_amask = amask | (32'h1 << num[4:0]);
						next_num = 32'h0;
					end else if (rx_data == acl_pkg::CH_EQ) begin
						next_cmd.axis_mask = pct ? num :
							(amask | (32'h1 << num[4:0]));
						next_num = 32'h0;
						next_ps = P_P1;
					end else
						next_ps = P_SKIP;
					P_P1: if (is_dig)
						next_num = 32'(num * 32'd10 + 32'(dig));
					else if (rx_data == acl_pkg::CH_COMMA) begin
						next_p1 = num;
						next_num = 32'h0;
						next_ps = P_P2;
					end else
						next_ps = P_SKIP;
					P_P2: if (is_dig)
						next_num = 32'(num * 32'd10 + 32'(dig));
					else
						next_ps = P_SKIP;
					P_SKIP: ;
				endcase
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ps <= P_NAME;
			ncnt <= 2'h0;
			name <= 24'h0;
			num <= 32'h0;
			amask <= 32'h0;
			pct <= 1'b0;
			p1 <= 32'h0;
			cmd <= '0;
		end else begin
			ps <= next_ps;
			ncnt <= next_ncnt;
			name <= next_name;
			num <= next_num;
			amask <= next_amask;
			pct <= next_pct;
			p1 <= next_p1;
			cmd <= next_cmd;
		end
	end

	// chain forwarding: host orders win, own sequence taken when idle
	always_comb begin
		next_fwd_valid = 1'b0;
		next_fwd_rec   = fwd_rec_o;
		next_fwd_mask  = fwd_mask_o;
		if (master && cmd.valid && !cmd.bad &&
			(cmd.axis_mask & ~32'h1) != 32'h0) begin // RULE_09 RULE_15
			next_fwd_valid = 1'b1;
			next_fwd_rec   = acl_pkg::REC_NORMAL; // RULE_14
			next_fwd_mask  = cmd.axis_mask;
		end else if (master && seq_req_i && (seq_rec_i == acl_pkg::REC_NORMAL ||
			seq_rec_i == acl_pkg::REC_EMERGENCY ||
			seq_rec_i == acl_pkg::REC_MONITOR)) begin // RULE_14
			next_fwd_valid = 1'b1;
			next_fwd_rec   = seq_rec_i;
			next_fwd_mask  = seq_mask_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			fwd_valid_o <= 1'b0;
			fwd_rec_o   <= 8'h00;
			fwd_mask_o  <= 32'h0;
		end else begin
			fwd_valid_o <= next_fwd_valid;
			fwd_rec_o   <= next_fwd_rec;
			fwd_mask_o  <= next_fwd_mask;
		end
	end

	assign cmd_o = cmd;
	assign bit_div_o = bit_div;
	assign host_link_rate_select_o = rate_store;
	assign operating_role_select_o = role_store;
	// master always answers as axis 0; strap limited to 0..30 by the user
	assign eff_axis_o = master ? acl_pkg::MASTER_AXIS : axis_number_i; // RULE_10 RULE_08
	assign status_monitoring_word_o =
		32'(master) << acl_pkg::STATUS_ROLE_BIT; // RULE_13
	assign present_axes_mask_o = master ?
		(chain_present_i & ~32'h1) : 32'h0; // RULE_17
	assign interp_ok_o = ext_master_i && !master; // RULE_16
endmodule : acl_core
`default_nettype wire

/* tb/acl_host_model.sv */
`timescale 1ns/1ns
`default_nettype none
module acl_host_model (
	input  wire logic        clk_i,     // base clock
	input  wire logic [15:0] bit_div_i, // clocks per bit at the host
	output var  logic        tx_o       // serial line, idle high
);
	initial tx_o = 1'b1;

	// start bit, eight data bits lsb first, stop bit; text goes out whole
	task automatic send(input string s);
		logic [9:0] f;
		for (int c = 0; c < s.len(); c++) begin
			f = {1'b1, s[c], 1'b0};
			for (int i = 0; i < 10; i++) begin
				tx_o <= f[i];
				repeat (bit_div_i) @(negedge clk_i);
			end
		end
	endtask : send
endmodule : acl_host_model
`default_nettype wire

/* tb/acl_core_sva.sv */
`timescale 1ns/1ns
`default_nettype none
module acl_core_sva (
	input wire logic                clk_i,          // clock
	input wire logic                rst_i,          // reset
	input wire logic [15:0]         fast_divide_count_i, // fast count
	input wire logic [15:0]         slow_divide_count_i, // slow count
	input wire logic [15:0]         current_divide_count_i, // cur count
	input wire logic                ext_master_i,   // ext master
	input wire logic                seq_req_i,      // own order
	input wire logic [7:0]          seq_rec_i,      // own record
	input wire acl_pkg::acl_ticks_t ticks_o,        // ticks
	input wire acl_pkg::acl_cmd_t   cmd_o,          // command
	input wire logic [31:0]         status_monitoring_word_o, // status
	input wire logic [31:0]         present_axes_mask_o, // axes mask
	input wire logic [4:0]          eff_axis_o,     // axis
	input wire logic                interp_ok_o,    // interp ok
	input wire logic                fwd_valid_o,    // fwd strobe
	input wire logic [7:0]          fwd_rec_o,      // fwd record
	input wire logic [31:0]         fwd_mask_o,     // fwd mask
	input wire logic                fast_service_o, // fast service
	input wire logic                slow_service_o  // slow service
);
	logic [15:0] cnt [3];
	logic [15:0] div [3];
	logic [2:0]  seen;
	logic [2:0]  tk;
	logic        mst;

	assign tk = {ticks_o.slow, ticks_o.fast, ticks_o.cur};
	assign div[0] = current_divide_count_i;
	assign div[1] = fast_divide_count_i;
	assign div[2] = slow_divide_count_i;
	assign mst = status_monitoring_word_o[acl_pkg::STATUS_ROLE_BIT];

	// the first pulse after reset has no reference, so it only arms
	always_ff @(posedge clk_i) begin
		for (int i = 0; i < 3; i++) begin
			if (rst_i || tk[i]) begin
				cnt[i] <= 16'h0001;
			end else begin
				cnt[i] <= cnt[i] + 16'h0001;
			end
			seen[i] <= !rst_i && (seen[i] || tk[i]);
		end
	end

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	sequence s_cmd_out;
		cmd_o.valid && !cmd_o.bad && mst
			&& (cmd_o.axis_mask & 32'hFFFFFFFE) != 32'h00000000;
	endsequence
	sequence s_fwd_cmd;
		fwd_valid_o && fwd_rec_o == acl_pkg::REC_NORMAL
			&& fwd_mask_o == $past(cmd_o.axis_mask);
	endsequence

	chk_fast_period: assert property (tk[1] && seen[1] |-> cnt[1] == div[1])
		else $error("fast tick period wrong");
	chk_cur_period: assert property (tk[0] && seen[0] |-> cnt[0] == div[0])
		else $error("current tick period wrong");
	chk_slow_period: assert property (tk[2] && seen[2] |-> cnt[2] == div[2])
		else $error("slow tick period wrong");
	chk_fast_service: assert property (fast_service_o == ticks_o.fast)
		else $error("fast service not on fast tick");
	chk_slow_service: assert property (slow_service_o == ticks_o.slow)
		else $error("slow service not on slow tick");
	chk_master_axis: assert property (mst |-> eff_axis_o == acl_pkg::MASTER_AXIS)
		else $error("master not on axis zero");
	chk_interp_lock: assert property ((mst && !ext_master_i) [*2] |-> !interp_ok_o)
		else $error("interpolation offered without external master");
	chk_mask_slave: assert property (!mst |-> present_axes_mask_o == 32'h00000000)
		else $error("axes mask shown by a slave");
	chk_cmd_fwd: assert property (s_cmd_out |=> s_fwd_cmd)
		else $error("host command not forwarded");
	chk_seq_fwd: assert property (seq_req_i && mst && !cmd_o.valid |=> fwd_valid_o && fwd_rec_o == $past(seq_rec_i))
		else $error("own record not forwarded");
	chk_role_boot: assert property (!$stable(mst) |-> $past(rst_i) || $past(rst_i, 2) || $past(rst_i, 3))
		else $error("role changed outside power-on");
endmodule : acl_core_sva

bind acl_core acl_core_sva u_sva (
	.clk_i(clk_i), .rst_i(rst_i), .ext_master_i(ext_master_i),
	.fast_divide_count_i(fast_divide_count_i),
	.slow_divide_count_i(slow_divide_count_i),
	.current_divide_count_i(current_divide_count_i),
	.seq_req_i(seq_req_i), .seq_rec_i(seq_rec_i), .ticks_o(ticks_o),
	.cmd_o(cmd_o), .status_monitoring_word_o(status_monitoring_word_o),
	.present_axes_mask_o(present_axes_mask_o), .eff_axis_o(eff_axis_o),
	.interp_ok_o(interp_ok_o), .fwd_valid_o(fwd_valid_o),
	.fwd_rec_o(fwd_rec_o), .fwd_mask_o(fwd_mask_o),
	.fast_service_o(fast_service_o), .slow_service_o(slow_service_o)
);
`default_nettype wire

/* tb/axis_command_link_timing_test.sv */
`timescale 1ns/1ns
`default_nettype none
module axis_command_link_timing_test;
	logic                clk_i = 1'b0;
	logic                rst_i = 1'b1;
	wire logic           rx_i;
	logic [15:0]         fdiv = 16'h000A;
	logic [15:0]         sdiv = 16'h0028;
	logic [15:0]         cdiv = 16'h0004;
	logic [31:0]         chain = 32'h00000016;
	logic                ext_master_i = 1'b0;
	logic                seq_req_i = 1'b0;
	logic [7:0]          seq_rec_i = 8'h00;
	logic [31:0]         seq_mask_i = 32'h00000000;
	acl_pkg::acl_ticks_t ticks_o;
	acl_pkg::acl_cmd_t   cmd_o;
	logic [31:0]         rate_o, role_o, status_o, present_o, fwd_mask_o;
	logic [15:0]         bit_div_o;
	logic [4:0]          eff_axis_o;
	logic                interp_ok_o, fwd_valid_o, fsv_o, ssv_o;
	logic [7:0]          fwd_rec_o;
	logic [7:0]          recs [3] = '{acl_pkg::REC_NORMAL,
		acl_pkg::REC_EMERGENCY, acl_pkg::REC_MONITOR};
	int                  mismatches = 0;
	int                  cmp_count = 0;

	always #20 clk_i = ~clk_i;

	acl_host_model host (.clk_i(clk_i), .bit_div_i(16'h00D9), .tx_o(rx_i));

	acl_core uut (
		.clk_i(clk_i), .rst_i(rst_i), .rx_i(rx_i),
		.fast_divide_count_i(fdiv), .slow_divide_count_i(sdiv),
		.current_divide_count_i(cdiv), .axis_number_i(5'h03),
		.ext_master_i(ext_master_i), .chain_present_i(chain),
		.seq_req_i(seq_req_i), .seq_rec_i(seq_rec_i),
		.seq_mask_i(seq_mask_i), .ticks_o(ticks_o), .cmd_o(cmd_o),
		.host_link_rate_select_o(rate_o), .operating_role_select_o(role_o),
		.status_monitoring_word_o(status_o), .present_axes_mask_o(present_o),
		.bit_div_o(bit_div_o), .eff_axis_o(eff_axis_o),
		.interp_ok_o(interp_ok_o), .fwd_valid_o(fwd_valid_o),
		.fwd_rec_o(fwd_rec_o), .fwd_mask_o(fwd_mask_o),
		.fast_service_o(fsv_o), .slow_service_o(ssv_o)
	);

	task automatic chk(input string nm, input logic [31:0] seen,
		input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic results();
		if (mismatches == 0 && cmp_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : results

	// stored settings only take effect here, like a power cycle
	task automatic boot(input int n);
		wait fork;
		rst_i <= 1'b1;
		repeat (n) @(negedge clk_i);
		rst_i <= 1'b0;
		repeat (3) @(negedge clk_i);
	endtask : boot

	// returns in the cycle the command shows; the stop bit still runs
	task automatic cmd(input string s);
		int n;
		n = 0;
		wait fork;
		fork
			host.send({s, "\015"});
		join_none
		while (cmd_o.valid !== 1'b1 && n < 40000) begin
			@(negedge clk_i);
			n++;
		end
		if (n >= 40000) begin
			mismatches++;
			results();
		end
	endtask : cmd

	task automatic seq_fwd(input logic [7:0] rec, input logic v);
		seq_req_i <= 1'b1;
		seq_rec_i <= rec;
		seq_mask_i <= 32'(rec);
		@(negedge clk_i);
		seq_req_i <= 1'b0;
		chk("fwd_valid", 32'(fwd_valid_o), 32'(v));
		if (v) begin
			chk("fwd_rec", 32'(fwd_rec_o), 32'(rec));
			chk("fwd_mask", fwd_mask_o, 32'(rec));
		end
		@(negedge clk_i);
	endtask : seq_fwd

	task automatic count_ticks();
		int f, s, c;
		f = 0;
		s = 0;
		c = 0;
		repeat (120) begin
			@(negedge clk_i);
			f += ticks_o.fast;
			s += ticks_o.slow;
			c += ticks_o.cur;
		end
		chk("fast_ticks", f, 32'(120 / fdiv));
		chk("slow_ticks", s, 32'(120 / sdiv));
		chk("cur_ticks", c, 32'(120 / cdiv));
	endtask : count_ticks

	initial begin
		boot(6);
		chk("role", role_o, acl_pkg::ROLE_RESET);
		chk("rate", rate_o, acl_pkg::RATE_RESET);
		chk("bit_div", 32'(bit_div_o), acl_pkg::CLK_HZ / acl_pkg::RATE_115200);
		chk("axis", 32'(eff_axis_o), 32'h00000003);
		chk("present", present_o, 32'h00000000);
		count_ticks();
		seq_fwd(acl_pkg::REC_NORMAL, 1'b0);
		ext_master_i <= 1'b1;
		repeat (2) @(negedge clk_i);
		chk("interp", 32'(interp_ok_o), 32'h00000001);
		ext_master_i <= 1'b0;
		cmd("ROL.3=1");
		chk("name", 32'(cmd_o.name), 32'(acl_pkg::CMD_ROLE));
		chk("sel", cmd_o.axis_mask, 32'h00000008);
		chk("p1", cmd_o.p1, 32'h00000001);
		chk("p2", cmd_o.p2, 32'h00000000);
		@(negedge clk_i);
		chk("role", role_o, acl_pkg::ROLE_MASTER);
		chk("role_bit", 32'(status_o[6]), 32'h00000000);
		// no field bus board is fitted, so master role is allowed
		boot(2);
		chk("role_bit", 32'(status_o[6]), 32'h00000001);
		chk("axis", 32'(eff_axis_o), 32'(acl_pkg::MASTER_AXIS));
		chk("interp", 32'(interp_ok_o), 32'h00000000);
		chk("present", present_o, chain);
		foreach (recs[i]) seq_fwd(recs[i], 1'b1);
		cmd("TST.%6=5");
		chk("sel", cmd_o.axis_mask, 32'h00000006);
		chk("p1", cmd_o.p1, 32'h00000005);
		chk("p2", cmd_o.p2, 32'h00000000);
		@(negedge clk_i);
		chk("fwd_valid", 32'(fwd_valid_o), 32'h00000001);
		chk("fwd_rec", 32'(fwd_rec_o), 32'(acl_pkg::REC_NORMAL));
		chk("fwd_mask", fwd_mask_o, 32'h00000006);
		cmd("WTM.31");
		chk("bad", 32'(cmd_o.bad), 32'h00000001);
		// one broadcast stores the same rate on every axis
		cmd("KLR.!=9600");
		@(negedge clk_i);
		chk("rate", rate_o, acl_pkg::RATE_9600);
		chk("bit_div", 32'(bit_div_o), acl_pkg::CLK_HZ / acl_pkg::RATE_115200);
		boot(2);
		chk("bit_div", 32'(bit_div_o), acl_pkg::CLK_HZ / acl_pkg::RATE_9600);
		chk("role_bit", 32'(status_o[6]), 32'h00000001);
		results();
	end
endmodule : axis_command_link_timing_test
`default_nettype wire
